// ### bench/acc_model.sv
// Accumulator of the execution datapath that drives the parity input
`timescale 1ns/1ps
module acc_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic accLoad,
    input wire logic [7:0] accIn,
    output logic [7:0] accValue_q
);
    // Held between loads, like the core's accumulator
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            accValue_q <= 8'h00;
        end else if (accLoad) begin
            accValue_q <= accIn;
        end
    end
endmodule

// ### bench/psw_mem_sva.sv
// Port checks for the status word and data memory block
`timescale 1ns/1ps
module psw_mem_checker
    import psw_mem_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [7:0] accValue,
    input wire logic aluReq,
    input wire psw_mem_pkg::alu_op_t aluOp,
    input wire logic [7:0] aluA,
    input wire logic [7:0] aluB,
    input wire logic memReq,
    input wire logic memWrite,
    input wire psw_mem_pkg::mem_mode_t memMode,
    input wire logic [7:0] memAddr,
    input wire logic pushReq,
    input wire logic popReq,
    input wire logic rdValid_q,
    input wire logic [7:0] program_status_word_q,
    input wire logic [7:0] stack_pointer_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // Request decode; a stack op hides the memory port that cycle
    wire stackOp = pushReq | popReq;
    wire memTake = clkEn & memReq & ~stackOp;
    wire readTake = (memTake & ~memWrite) | (clkEn & popReq & ~pushReq);
    wire pswHit = memAddr[7:3] == 5'h1a;
    wire pswByte = memMode == MODE_DIRECT && memAddr == PSW_ADDR;
    wire pswBit = memMode == MODE_BIT && pswHit;
    wire pswWrite = memTake & memWrite & (pswByte | pswBit);
    wire flagTake = clkEn & aluReq & ~pswWrite;
    wire [8:0] addSum = {1'b0, aluA} + {1'b0, aluB};
    wire [15:0] mulProd = {8'h00, aluA} * {8'h00, aluB};
    wire addOver = (aluA[7] == aluB[7]) && (addSum[7] != aluA[7]);
    wire [7:0] psw = program_status_word_q;
    ////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (
        clkEn |=> rdValid_q == $past(readTake))
        else $error("read answer missing or spurious");
    push_bump_a: assert property (clkEn && pushReq |=>
        stack_pointer_q == $past(stack_pointer_q) + 8'h01)
        else $error("push did not bump stack pointer");
    pop_drop_a: assert property (clkEn && popReq && !pushReq |=>
        stack_pointer_q == $past(stack_pointer_q) - 8'h01)
        else $error("pop did not drop stack pointer");
    reset_value_a: assert property ($rose(arst_n) |->
        psw == PSW_RESET && stack_pointer_q == SP_RESET)
        else $error("reset values wrong");
    parity_follow_a: assert property (
        clkEn |=> psw[0] == ^$past(accValue))
        else $error("parity does not follow accumulator");
    add_flags_a: assert property (
        flagTake && aluOp == ALU_ADD |=>
        psw[7] == $past(addSum[8]) && psw[2] == $past(addOver) &&
        psw[6] == $past(aluA[4] ^ aluB[4] ^ addSum[4]))
        else $error("add flags wrong");
    mul_over_a: assert property (flagTake && aluOp == ALU_MUL |=>
        psw[2] == ($past(mulProd) > 16'h00ff) && !psw[7])
        else $error("multiply overflow wrong");
    div_zero_a: assert property (
        flagTake && aluOp == ALU_DIV |=>
        psw[2] == ($past(aluB) == 8'h00))
        else $error("divide overflow wrong");
    user_flags_a: assert property (
        !pswWrite |=> $stable(psw[5]) && $stable(psw[1]))
        else $error("user flag changed without write");
endmodule

bind psw_data_memory psw_mem_checker sva(.sys_clk(sys_clk), .arst_n(arst_n),
    .clkEn(clkEn), .accValue(accValue), .aluReq(aluReq), .aluOp(aluOp),
    .aluA(aluA), .aluB(aluB), .memReq(memReq), .memWrite(memWrite),
    .memMode(memMode), .memAddr(memAddr), .pushReq(pushReq),
    .popReq(popReq), .rdValid_q(rdValid_q),
    .program_status_word_q(program_status_word_q),
    .stack_pointer_q(stack_pointer_q));

// ### bench/tb.sv
// Self-checking bench for the status word and data memory block
`timescale 1ns/1ps
module tb;
    import psw_mem_pkg::*;
    logic sys_clk = 1'b0, arst_n = 1'b0, accLoad = 1'b0, aluReq = 1'b0;
    logic memReq = 1'b0, memWrite = 1'b0, memWrBit = 1'b0;
    logic pushReq = 1'b0, popReq = 1'b0, rdBit, rdValid, clkEn = 1'b1;
    logic [7:0] accIn = 8'h00, aluA = 8'h00, aluB = 8'h00, memAddr = 8'h00;
    logic [7:0] memWrData = 8'h00, pushData = 8'h00, accValue, rdData, psw, sp;
    alu_op_t aluOp = ALU_ADD;
    mem_mode_t memMode = MODE_DIRECT;
    int miscompares = 0, checks = 0;
    // Op, operand A, operand B, expected {carry, half carry, overflow}
    logic [21:0] flagCases [10] = '{{3'h0, 16'h7f01, 3'b011},
        {3'h0, 16'hff01, 3'b110}, {3'h1, 16'h0000, 3'b000},
        {3'h2, 16'h0001, 3'b110}, {3'h2, 16'h8000, 3'b011},
        {3'h3, 16'h1010, 3'b001}, {3'h3, 16'h0f11, 3'b000},
        {3'h4, 16'h0500, 3'b001}, {3'h5, 16'h0500, 3'b001},
        {3'h4, 16'h0501, 3'b000}};
    acc_model partner(.sys_clk(sys_clk), .arst_n(arst_n), .accLoad(accLoad),
        .accIn(accIn), .accValue_q(accValue));
    psw_data_memory dut(.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn),
        .accValue(accValue), .aluReq(aluReq), .aluOp(aluOp), .aluA(aluA),
        .aluB(aluB), .memReq(memReq), .memWrite(memWrite), .memMode(memMode),
        .memAddr(memAddr), .memWrData(memWrData), .memWrBit(memWrBit),
        .pushReq(pushReq), .popReq(popReq), .pushData(pushData),
        .rdData_q(rdData), .rdBit_q(rdBit), .rdValid_q(rdValid),
        .program_status_word_q(psw), .stack_pointer_q(sp));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One access, idle cycle first so the strobe never flips twice at once
    task automatic mem(input logic w, input mem_mode_t m, input logic [7:0] a,
        input logic [7:0] d);
        @(negedge sys_clk);
        memReq = 1'b1;
        memWrite = w;
        memMode = m;
        memAddr = a;
        memWrData = d;
        memWrBit = d[0];
        @(negedge sys_clk);
        memReq = 1'b0;
    endtask
    task automatic rd(input mem_mode_t m, input logic [7:0] a,
        input logic [7:0] exp);
        mem(1'b0, m, a, 8'h00);
        chk({7'h0, rdValid}, 8'h01);
        chk(rdData, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_stack();
        pushReq = 1'b1;
        pushData = 8'haa;
        @(negedge sys_clk);
        pushData = 8'h55;
        @(negedge sys_clk);
        pushReq = 1'b0;
        chk(sp, 8'h09);
        rd(MODE_DIRECT, 8'h08, 8'haa);
        popReq = 1'b1;
        @(negedge sys_clk);
        popReq = 1'b0;
        chk(rdData, 8'h55);
        mem(1'b1, MODE_DIRECT, SP_ADDR, 8'hfe);
        pushReq = 1'b1;
        pushData = 8'h3c;
        @(negedge sys_clk);
        pushReq = 1'b0;
        chk(sp, 8'hff);
        mem(1'b1, MODE_REGISTER, 8'h00, 8'hff);
        rd(MODE_INDIRECT, 8'h00, 8'h3c);
        // Clock enable low must swallow a push
        clkEn = 1'b0;
        pushReq = 1'b1;
        @(negedge sys_clk);
        pushReq = 1'b0;
        clkEn = 1'b1;
        chk(sp, 8'hff);
    endtask
    // Back-to-back flag updates; carry chains into add_with_carry_instruction and subtract_borrow_instruction
    task automatic t_flags();
        aluReq = 1'b1;
        for (int i = 0; i < 10; i++) begin
            aluOp = alu_op_t'(flagCases[i][21:19]);
            {aluA, aluB} = flagCases[i][18:3];
            @(negedge sys_clk);
            chk({5'h0, psw[7:6], psw[2]},
                {5'h0, flagCases[i][2:0]});
        end
        aluReq = 1'b0;
    endtask
    task automatic t_status();
        mem(1'b1, MODE_DIRECT, PSW_ADDR, 8'hff);
        chk(psw, 8'hfe);
        mem(1'b1, MODE_BIT, 8'hd5, 8'h00);
        rd(MODE_DIRECT, PSW_ADDR, 8'hde);
        mem(1'b0, MODE_BIT, 8'hd1, 8'h00);
        chk({7'h0, rdBit}, 8'h01);
        for (int i = 0; i < 2; i++) begin
            accIn = i ? 8'h03 : 8'h07;
            accLoad = 1'b1;
            @(negedge sys_clk);
            accLoad = 1'b0;
            @(negedge sys_clk);
            chk({7'h0, psw[0]}, {7'h0, ^accIn});
        end
    endtask
    // Same register number in every bank must land in four places
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            mem(1'b1, MODE_DIRECT, PSW_ADDR, {3'h0, b[1:0], 3'h0});
            mem(1'b1, MODE_REGISTER, 8'h02, 8'h40 + 8'(b));
        end
        mem(1'b1, MODE_DIRECT, PSW_ADDR, 8'h00);
        for (int b = 0; b < 4; b++) begin
            rd(MODE_DIRECT, {3'h0, b[1:0], 3'h2}, 8'h40 + 8'(b));
        end
    endtask
    task automatic t_space();
        mem(1'b1, MODE_REGISTER, 8'h00, 8'h90);
        mem(1'b1, MODE_REGISTER, 8'h01, 8'h30);
        mem(1'b1, MODE_INDIRECT, 8'h00, 8'h5a);
        mem(1'b1, MODE_DIRECT, 8'h90, 8'ha5);
        mem(1'b1, MODE_DIRECT, 8'h30, 8'h6b);
        rd(MODE_DIRECT, 8'h90, SFR_READ_DEFAULT);
        rd(MODE_INDIRECT, 8'h00, 8'h5a);
        rd(MODE_INDIRECT, 8'h01, 8'h6b);
        mem(1'b1, MODE_DIRECT, 8'h22, 8'h00);
        mem(1'b1, MODE_BIT, 8'h13, 8'h01);
        rd(MODE_DIRECT, 8'h22, 8'h08);
        mem(1'b0, MODE_BIT, 8'h13, 8'h00);
        chk({7'h0, rdBit}, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
        chk(psw, PSW_RESET);
        chk(sp, SP_RESET);
        t_stack();
        t_flags();
        t_status();
        t_banks();
        t_space();
        finish_test();
    end
    // Over twenty times the expected run
    initial begin
        repeat (2000) @(posedge sys_clk);
        miscompares++;
        finish_test();
    end
endmodule

// ### verilog/psw_data_memory.sv
// Status word, stack pointer and 256-byte internal data memory
//
// Overview of operation
// - Carry flag bit 7 set on add carry or subtract borrow, else cleared.
// - Half-carry bit 6 set on nibble carry or borrow, else cleared.
// - User flags bits 5 and 1 change only by software writes.
// - Bank select bits 4:3 place registers at 0x00, 0x08, 0x10 or 0x18.
// - Overflow bit 2 set on signed overflow of add, add_with_carry_instruction or subtract_borrow_instruction.
// - Overflow set when a multiply product exceeds 255.
// - Overflow set when dividing by zero.
// - Those five operations clear overflow when no overflow occurs.
// - Parity bit 0 is one when accumulator holds odd count of ones.
// - Status word at 0xD0, byte and bit access, resets to zero.
// - Lower 128 bytes reachable by direct and indirect access.
// - Above 0x7F direct goes to special registers, indirect to upper RAM.
// - One bank active; eight working registers resolve into it.
// - Indirect pointer comes from register 0 or 1 of active bank.
// - Bytes 0x20-0x2F bit addressable; bit address 8*offset plus bit.
// - Bit or byte access is chosen only by the operand type.
// - Stack pointer marks last used slot; push writes pointer+1 then bumps.
// - Reset loads stack pointer 0x07 so first push lands at 0x08.
// - Stack may live anywhere in 256 bytes, up to 256 deep.
// - Direct operand 0x00-0x7F selects RAM, 0x80-0xFF special registers.
//
// Port behaviour in brief
// - One memory access per enabled cycle on the memory port.
// - Push or pop takes the cycle; a memory request then is dropped.
// - Push beats pop when both arrive together.
// - Reads answer one cycle later with a one-cycle valid pulse.
// - Read data holds until the next read or pop.
// - Writes land at the taking edge; the next read sees them.
// - Read-after-write back to back needs no gap.
//
// Flags
// - Software status write beats a flag update in the same cycle.
// - Add with carry and subtract use the carry held before the update.
// - Multiply, divide and other ops clear carry and half carry.
// - The other-op code leaves overflow untouched.
// - Overflow for divide looks only at a zero divisor.
// - Parity is rebuilt from the accumulator every enabled cycle.
// - Parity shows one cycle after the accumulator changes.
// - A write to the parity bit is dropped; the store keeps it zero.
//
// Special space
// - Only the status word and stack pointer live here.
// - Other special addresses read zero and drop writes.
// - Bit access to special space reaches registers whose address ends in 0 or 8.
// - Bit writes are read-modify-write of the whole holding byte.
//
// Banks and stack
// - Pointers and register numbers use the bank at request time.
// - A bank switch and a register access in one cycle use the old bank.
// - Stack pointer wraps from 0xFF to 0x00; no overflow is flagged.
// - A stack on top of register banks will overwrite them.
//
// Limitations
// - RAM has no reset; software must write before it reads.
// - Clock enable low freezes every flop, outputs included.
// - One read port: a pop hides any memory read of that cycle.
`timescale 1ns/1ps

module psw_data_memory
    import psw_mem_pkg::*;
#(
    parameter int RAM_DEPTH = 256
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [7:0] accValue,
    input wire logic aluReq,
    input wire psw_mem_pkg::alu_op_t aluOp,
    input wire logic [7:0] aluA,
    input wire logic [7:0] aluB,
    input wire logic memReq,
    input wire logic memWrite,
    input wire psw_mem_pkg::mem_mode_t memMode,
    input wire logic [7:0] memAddr,
    input wire logic [7:0] memWrData,
    input wire logic memWrBit,
    input wire logic pushReq,
    input wire logic popReq,
    input wire logic [7:0] pushData,
    output logic [7:0] rdData_q,
    output logic rdBit_q,
    output logic rdValid_q,
    output logic [7:0] program_status_word_q,
    output logic [7:0] stack_pointer_q
);
    import psw_mem_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    // Depth is a parameter so a smaller derivative can trim the array
    // Status and pointer reset; the array deliberately does not
    logic [7:0] ram [RAM_DEPTH];
    logic [7:0] pswStore_q;
    logic [7:0] pswStore_d;
    logic [7:0] sp_d;
    logic parity_q;

    // Odd count of ones in a byte
    function automatic logic oddParity(input logic [7:0] v);
        oddParity = ^v;
    endfunction

    // Byte address of a working register in the active bank
    function automatic logic [7:0] regAddr(input logic [1:0] bank,
                                           input logic [2:0] idx);
        regAddr = {3'b000, bank, idx};
    endfunction

    // Byte that holds a given bit address
    // Low half: sixteen RAM bytes from 0x20, eight bits each
    // High half: special registers whose address ends in 0 or 8
    function automatic logic [7:0] bitByte(input logic [7:0] bitAddr);
        if (bitAddr[7]) begin
            bitByte = {bitAddr[7:3], 3'b000};
        end else begin
            bitByte = {BIT_AREA_HI, bitAddr[6:3]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    // Pointer and register lookups use the bank held at request time
    wire logic [1:0] bankSelect = pswStore_q[BANK_HI_BIT:BANK_LO_BIT];
    // Full status word view, parity taken from the live flop
    wire logic [7:0] pswView = {pswStore_q[7:1], parity_q};
    // Pointer for indirect access from register 0 or 1
    wire logic [7:0] ptrAddr = regAddr(bankSelect, {2'b00, memAddr[0]});
    wire logic [7:0] ptrValue = ram[ptrAddr];
    wire logic [7:0] bitHome = bitByte(memAddr);
    logic [7:0] targetAddr;
    logic directSpace;

    // Effective byte address per addressing mode
    always_comb begin
        targetAddr = memAddr;
        directSpace = 1'b0;
        case (memMode)
            MODE_DIRECT: begin
                targetAddr = memAddr;
                directSpace = 1'b1;
            end
            MODE_INDIRECT: begin
                targetAddr = ptrValue;
                directSpace = 1'b0;
            end
            MODE_REGISTER: begin
                targetAddr = regAddr(bankSelect, memAddr[2:0]);
                directSpace = 1'b0;
            end
            MODE_BIT: begin
                targetAddr = bitHome;
                directSpace = 1'b1;
            end
            default: begin
                targetAddr = memAddr;
                directSpace = 1'b0;
            end
        endcase
    end

    // Direct operands at or above 0x80 leave RAM for the special registers
    // Indirect ones never do, so upper RAM hides behind the same numbers
    wire logic toSfr = directSpace &&
                       (targetAddr >= UPPER_BASE);
    wire logic isBitOp = (memMode == MODE_BIT);
    wire logic hitPsw = toSfr && (targetAddr == PSW_ADDR);
    wire logic hitSp = toSfr && (targetAddr == SP_ADDR);
    // Unoccupied special registers read as zero and drop writes
    wire logic [7:0] sfrValue = hitPsw ? pswView :
                                hitSp ? stack_pointer_q : SFR_READ_DEFAULT;
    wire logic [7:0] oldByte = toSfr ? sfrValue : ram[targetAddr];
    wire logic [2:0] bitPos = memAddr[2:0];
    logic [7:0] newByte;

    // Bit writes are read-modify-write of the holding byte
    always_comb begin
        newByte = oldByte;
        if (isBitOp) begin
            newByte[bitPos] = memWrBit;
        end else begin
            newByte = memWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request arbitration: a stack operation takes the cycle
    // A memory request that loses is dropped, not queued
    wire logic stackOp = pushReq || popReq;
    wire logic memGo = memReq && !stackOp;
    wire logic memWe = memGo && memWrite;
    wire logic ramWe = memWe && !toSfr;
    wire logic pswWe = memWe && hitPsw;
    wire logic spWe = memWe && hitSp;
    // Reads that owe an answer next cycle; push beats pop
    wire logic popTake = popReq && !pushReq;
    wire logic memRead = memGo && !memWrite;
    // Stack slots span the whole RAM, wrapping at 0xFF
    wire logic [7:0] spNext = stack_pointer_q + 8'h01;
    wire logic [7:0] spPrev = stack_pointer_q - 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // Flag arithmetic
    // Wide sums expose the carry out of bit 7 and out of bit 3
    // Borrows show as the top bit of the wide difference
    wire logic carryIn = ((aluOp == ALU_ADD_WITH_CARRY_INSTRUCTION) || (aluOp == ALU_SUBTRACT_BORROW_INSTRUCTION)) ?
                         pswStore_q[CARRY_BIT] : 1'b0;
    wire logic [8:0] sum9 = {1'b0, aluA} + {1'b0, aluB} + {8'h00, carryIn};
    wire logic [4:0] sumNib = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} +
                              {4'h0, carryIn};
    wire logic [8:0] diff9 = {1'b0, aluA} - {1'b0, aluB} - {8'h00, carryIn};
    wire logic [4:0] diffNib = {1'b0, aluA[3:0]} - {1'b0, aluB[3:0]} -
                               {4'h0, carryIn};
    wire logic [15:0] product = {8'h00, aluA} * {8'h00, aluB};
    // Signed overflow: the result sign disagrees with the operands
    wire logic addOv = (aluA[7] == aluB[7]) && (sum9[7] != aluA[7]);
    wire logic subOv = (aluA[7] != aluB[7]) && (diff9[7] != aluA[7]);
    logic newCarry;
    logic newHalf;
    logic newOv;

    // Flag results per operation
    always_comb begin
        newCarry = 1'b0;
        newHalf = 1'b0;
        newOv = pswStore_q[OVERFLOW_BIT];
        case (aluOp)
            ALU_ADD, ALU_ADD_WITH_CARRY_INSTRUCTION: begin
                newCarry = sum9[8];
                newHalf = sumNib[4];
                newOv = addOv;
            end
            ALU_SUBTRACT_BORROW_INSTRUCTION: begin
                newCarry = diff9[8];
                newHalf = diffNib[4];
                newOv = subOv;
            end
            ALU_MUL: begin
                newOv = |product[15:8];
            end
            ALU_DIV: begin
                newOv = (aluB == 8'h00);
            end
            ALU_OTHER: begin
                newOv = pswStore_q[OVERFLOW_BIT];
            end
            default: begin
                newOv = pswStore_q[OVERFLOW_BIT];
            end
        endcase
    end

    // Status word next value; software write beats a flag update
    // Bit 0 stays zero in store; the published view adds parity
    always_comb begin
        pswStore_d = pswStore_q;
        if (pswWe) begin
            pswStore_d = newByte;
        end else if (aluReq) begin
            pswStore_d[CARRY_BIT] = newCarry;
            pswStore_d[HALF_CARRY_BIT] = newHalf;
            pswStore_d[OVERFLOW_BIT] = newOv;
        end
        pswStore_d[PARITY_BIT] = 1'b0;
    end

    // Stack pointer next value
    // A direct write of the pointer loses to a push or pop that cycle
    always_comb begin
        sp_d = stack_pointer_q;
        if (pushReq) begin
            sp_d = spNext;
        end else if (popReq) begin
            sp_d = spPrev;
        end else if (spWe) begin
            sp_d = newByte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word and stack pointer flops
    // All frozen while the clock enable is low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pswStore_q <= PSW_RESET;
            stack_pointer_q <= SP_RESET;
            parity_q <= 1'b0;
        end else if (clkEn) begin
            pswStore_q <= pswStore_d;
            stack_pointer_q <= sp_d;
            parity_q <= oddParity(accValue);
        end
    end

    // Published status word, refreshed every enabled cycle
    // Built from next values so it matches the store one edge on
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            program_status_word_q <= PSW_RESET;
        end else if (clkEn) begin
            program_status_word_q <= {pswStore_d[7:1], oddParity(accValue)};
        end
    end

    // RAM writes; no reset, contents are undefined after power-up
    // A push and a memory write never land together; push wins
    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            if (pushReq) begin
                ram[spNext] <= pushData;
            end else if (ramWe) begin
                ram[targetAddr] <= newByte;
            end
        end
    end

    // Read answer one cycle after the request
    // Data holds between answers so a slow reader may still take it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_q <= 8'h00;
            rdBit_q <= 1'b0;
            rdValid_q <= 1'b0;
        end else if (clkEn) begin
            rdValid_q <= memRead || popTake;
            if (popTake) begin
                rdData_q <= ram[stack_pointer_q];
                rdBit_q <= 1'b0;
            end else if (memRead) begin
                rdData_q <= oldByte;
                rdBit_q <= oldByte[bitPos];
            end
        end
    end

endmodule

// ### verilog/psw_mem_pkg.sv
// Constants and types shared by the status word and data memory block
package psw_mem_pkg;
    // Special register addresses
    localparam logic [7:0] PSW_ADDR = 8'hd0;
    localparam logic [7:0] SP_ADDR = 8'h81;
    // Reset values
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'h07;
    // Status word field positions
    localparam int CARRY_BIT = 7;
    localparam int HALF_CARRY_BIT = 6;
    localparam int USER_ZERO_BIT = 5;
    localparam int BANK_HI_BIT = 4;
    localparam int BANK_LO_BIT = 3;
    localparam int OVERFLOW_BIT = 2;
    localparam int USER_ONE_BIT = 1;
    localparam int PARITY_BIT = 0;
    // Memory layout
    localparam logic [7:0] UPPER_BASE = 8'h80;
    localparam logic [3:0] BIT_AREA_HI = 4'h2;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [7:0] SFR_READ_DEFAULT = 8'h00;

    // Arithmetic operation that updates the flags
    typedef enum logic [2:0] {
        ALU_ADD = 3'b000,
        ALU_ADD_WITH_CARRY_INSTRUCTION = 3'b001,
        ALU_SUBTRACT_BORROW_INSTRUCTION = 3'b010,
        ALU_MUL = 3'b011,
        ALU_DIV = 3'b100,
        ALU_OTHER = 3'b101
    } alu_op_t;

    // How a memory operand is addressed
    typedef enum logic [1:0] {
        MODE_DIRECT = 2'b00,
        MODE_INDIRECT = 2'b01,
        MODE_REGISTER = 2'b10,
        MODE_BIT = 2'b11
    } mem_mode_t;
endpackage
